// >>> verilog/tao_pkg.sv
// shared constants and carrier types of the thermal alarm block
package tao_pkg;

  // --------------------------------------------------------------
  // widths
  // --------------------------------------------------------------
  localparam int TEMP_W = 8;
  localparam int ADDR_W = 8;
  localparam int NCH = 2;
  localparam int CH_LOC = 0;
  localparam int CH_REM = 1;
  localparam int STAT_W = 7;
  localparam int PIN_W = 3;

  // --------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_LOC_TEMP = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_REM_TEMP = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_LIM_BASE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_HYST = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_OFFSET = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_PINS = 8'h38;
  localparam logic [ADDR_W-1:0] LIM_STRIDE = 8'h04;
  localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h0C;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int ST_LOC_HIGH = 0;
  localparam int ST_LOC_LOW = 1;
  localparam int ST_OPEN = 2;
  localparam int ST_REM_HIGH = 3;
  localparam int ST_REM_LOW = 4;
  localparam int ST_LOC_FS = 5;
  localparam int ST_REM_FS = 6;
  localparam int CFG_MASK_BIT = 0;
  localparam int CFG_PIN_BIT = 1;
  localparam int PIN_OPEN = 0;
  localparam int PIN_ALARM = 1;
  localparam int PIN_FS = 2;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0] HYST_RST = 8'h0A;
  localparam logic [TEMP_W-1:0] HIGH_RST = 8'h55;
  localparam logic [TEMP_W-1:0] LOW_RST = 8'h7F;
  localparam logic [TEMP_W-1:0] FS_RST = 8'h5A;
  localparam logic [TEMP_W-1:0] OFFSET_RST = 8'h00;
  localparam logic [STAT_W-1:0] ENABLE_RST = 7'h7F;
  localparam logic [1:0] CFG_RST = 2'h0;
  // arbitrary device address, answered on an alert response read
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------
  // carrier types
  // --------------------------------------------------------------
  typedef struct packed {
    logic [TEMP_W-1:0] high;
    logic [TEMP_W-1:0] low;
    logic [TEMP_W-1:0] fs;
  } tao_lim_s;

  typedef struct packed {
    logic high_exc;
    logic low_exc;
    logic fs_on;
    logic sec_on;
  } tao_cmp_s;

  typedef struct packed {
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [NCH-1:0][TEMP_W-1:0] temp;
    tao_lim_s [NCH-1:0] lim;
    logic [7:0] hyst;
    logic [TEMP_W-1:0] offset;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] enable;
    logic [1:0] cfg;
    logic eval;
    logic alarm_on;
    logic alarm_oe;
    logic fs_oe;
    logic irq;
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
  } tao_state_s;

endpackage

// >>> verilog/tao_chan_cmp.sv
// limit comparator with hysteresis for one temperature channel
`timescale 1ns/1ps
module tao_chan_cmp
  import tao_pkg::*;
#(
  parameter int W = TEMP_W
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // evaluation strobe and operands
  input wire logic i_eval,
  input wire logic [W-1:0] i_temp,
  input wire logic [W-1:0] i_high,
  input wire logic [W-1:0] i_low,
  input wire logic [W-1:0] i_fs,
  input wire logic [7:0] i_hyst,
  // comparison flags
  output tao_cmp_s o_flags
);

  tao_cmp_s st_reg;
  tao_cmp_s st_next;
  logic signed [W+1:0] t_x;
  logic signed [W+1:0] hi_x;
  logic signed [W+1:0] lo_x;
  logic signed [W+1:0] fs_x;
  logic signed [W+1:0] hy_x;

  if (W < 8 || W > 16)
  begin : g_chk
    $error("tao_chan_cmp: W must lie in 8..16");
  end

  // ----------------------------------------------------------------
  // compare on each evaluation strobe
  // ----------------------------------------------------------------
  always_comb
  begin
    t_x = (W+2)'($signed(i_temp));
    hi_x = (W+2)'($signed(i_high));
    lo_x = (W+2)'($signed(i_low));
    fs_x = (W+2)'($signed(i_fs));
    hy_x = (W+2)'($signed({1'b0, i_hyst}));
    st_next = st_reg;
    if (i_eval)
    begin
      st_next.high_exc = t_x > hi_x;
      st_next.low_exc = t_x >= lo_x;
      if (t_x > fs_x)
        st_next.fs_on = 1'b1;
      else if (t_x <= fs_x - hy_x)
        st_next.fs_on = 1'b0;
      if (t_x > hi_x)
        st_next.sec_on = 1'b1;
      else if (t_x <= hi_x - hy_x)
        st_next.sec_on = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_flags = st_reg;

endmodule

// >>> verilog/tao_alarm_top.sv
// alarm and fail-safe output logic of a two-channel temperature monitor
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module tao_alarm_top
  import tao_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
)
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // axi4-lite write address and data
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // axi4-lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // axi4-lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // conversion engine
  input wire logic I_CONV_START,
  input wire logic I_CONV_DONE,
  input wire logic [TEMP_W-1:0] I_LOCAL_RESULT,
  input wire logic [TEMP_W-1:0] I_REMOTE_RESULT,
  input wire logic I_DIODE_OPEN,
  // alert response from the bus slave
  input wire logic I_ARA_READ,
  output logic O_ARA_ANSWER,
  output logic [6:0] O_ARA_ADDR,
  // shared pin: limit_alarm_n or secondary_failsafe_n
  input wire logic I_LIMIT_ALARM_N,
  output logic O_LIMIT_ALARM_N,
  output logic O_LIMIT_ALARM_OE,
  // overtemp_failsafe_n pin
  input wire logic I_OVERTEMP_FAILSAFE_N,
  output logic O_OVERTEMP_FAILSAFE_N,
  output logic O_OVERTEMP_FAILSAFE_OE,
  // interrupt
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // per-channel comparators
  // ----------------------------------------------------------------
  tao_state_s s_reg;
  tao_state_s s_next;
  tao_cmp_s [NCH-1:0] cmp;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    tao_chan_cmp #(
      .W(TEMP_W)
    ) u_cmp (
      .i_clk(I_CLK),
      .i_rst_n(rst_n),
      .i_eval(s_reg.eval),
      .i_temp(s_reg.temp[c]),
      .i_high(s_reg.lim[c].high),
      .i_low(s_reg.lim[c].low),
      .i_fs(s_reg.lim[c].fs),
      .i_hyst(s_reg.hyst),
      .o_flags(cmp[c])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;
  logic do_wr;
  logic wr_hit;
  logic lim_wr;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [STAT_W-1:0] clr;
  logic [STAT_W-1:0] ev;
  logic [TEMP_W:0] sum;
  logic [TEMP_W-1:0] rem_adj;
  logic any_high;
  logic pin_sec;

  always_comb
  begin
    s_next = s_reg;
    aw_rdy = !s_reg.aw_hold && !s_reg.bvalid;
    w_rdy = !s_reg.w_hold && !s_reg.bvalid;
    ar_rdy = !s_reg.rvalid;
    do_wr = s_reg.aw_hold && s_reg.w_hold;
    wr_hit = 1'b0;
    lim_wr = 1'b0;
    rd_hit = 1'b0;
    rd_val = 32'h0;
    clr = '0;
    pin_sec = s_reg.cfg[CFG_PIN_BIT];
    any_high = cmp[CH_LOC].high_exc || cmp[CH_REM].high_exc;

    // pin synchronisers
    s_next.sync1 = {!I_OVERTEMP_FAILSAFE_N, !I_LIMIT_ALARM_N, I_DIODE_OPEN};
    s_next.sync2 = s_reg.sync1;

    // write channel capture
    if (I_AWVALID && aw_rdy)
    begin
      s_next.aw_hold = 1'b1;
      s_next.awaddr = I_AWADDR;
    end
    if (I_WVALID && w_rdy)
    begin
      s_next.w_hold = 1'b1;
      s_next.wdata = I_WDATA[7:0];
      s_next.wstb0 = I_WSTRB[0];
    end
    if (s_reg.bvalid && I_BREADY)
      s_next.bvalid = 1'b0;

    // register write
    if (do_wr)
    begin
      s_next.aw_hold = 1'b0;
      s_next.w_hold = 1'b0;
      s_next.bvalid = 1'b1;
      wr_hit = 1'b1;
      case (s_reg.awaddr)
        OFF_LOC_TEMP, OFF_REM_TEMP, OFF_STATUS, OFF_PINS:
          wr_hit = 1'b1;
        OFF_CLEAR:
          if (s_reg.wstb0)
            clr = s_reg.wdata[STAT_W-1:0];
        OFF_ENABLE:
          if (s_reg.wstb0)
            s_next.enable = s_reg.wdata[STAT_W-1:0];
        OFF_CONFIG:
          if (s_reg.wstb0)
            s_next.cfg = s_reg.wdata[1:0];
        OFF_HYST:
          if (s_reg.wstb0)
          begin
            s_next.hyst = s_reg.wdata;
            lim_wr = 1'b1;
          end
        OFF_OFFSET:
          if (s_reg.wstb0)
            s_next.offset = s_reg.wdata[TEMP_W-1:0];
        default:
          wr_hit = 1'b0;
      endcase
      for (int c = 0; c < NCH; c++)
      begin
        if (s_reg.awaddr == OFF_LIM_BASE + ADDR_W'(c) * CH_STRIDE)
        begin
          wr_hit = 1'b1;
          lim_wr = s_reg.wstb0;
          if (s_reg.wstb0)
            s_next.lim[c].high = s_reg.wdata[TEMP_W-1:0];
        end
        if (s_reg.awaddr == OFF_LIM_BASE + ADDR_W'(c) * CH_STRIDE + LIM_STRIDE)
        begin
          wr_hit = 1'b1;
          lim_wr = s_reg.wstb0;
          if (s_reg.wstb0)
            s_next.lim[c].low = s_reg.wdata[TEMP_W-1:0];
        end
        if (s_reg.awaddr == OFF_LIM_BASE + ADDR_W'(c) * CH_STRIDE + 2 * LIM_STRIDE)
        begin
          wr_hit = 1'b1;
          lim_wr = s_reg.wstb0;
          if (s_reg.wstb0)
            s_next.lim[c].fs = s_reg.wdata[TEMP_W-1:0];
        end
      end
      s_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // register read
    if (s_reg.rvalid && I_RREADY)
      s_next.rvalid = 1'b0;
    if (I_ARVALID && ar_rdy)
    begin
      rd_hit = 1'b1;
      case (I_ARADDR)
        OFF_LOC_TEMP:
          rd_val = 32'(s_reg.temp[CH_LOC]);
        OFF_REM_TEMP:
          rd_val = 32'(s_reg.temp[CH_REM]);
        OFF_STATUS:
          rd_val = 32'(s_reg.status);
        OFF_CLEAR:
          rd_val = 32'h0;
        OFF_ENABLE:
          rd_val = 32'(s_reg.enable);
        OFF_CONFIG:
          rd_val = 32'(s_reg.cfg);
        OFF_HYST:
          rd_val = 32'(s_reg.hyst);
        OFF_OFFSET:
          rd_val = 32'(s_reg.offset);
        OFF_PINS:
          rd_val = 32'(s_reg.sync2);
        default:
          rd_hit = 1'b0;
      endcase
      for (int c = 0; c < NCH; c++)
      begin
        if (I_ARADDR == OFF_LIM_BASE + ADDR_W'(c) * CH_STRIDE)
        begin
          rd_hit = 1'b1;
          rd_val = 32'(s_reg.lim[c].high);
        end
        if (I_ARADDR == OFF_LIM_BASE + ADDR_W'(c) * CH_STRIDE + LIM_STRIDE)
        begin
          rd_hit = 1'b1;
          rd_val = 32'(s_reg.lim[c].low);
        end
        if (I_ARADDR == OFF_LIM_BASE + ADDR_W'(c) * CH_STRIDE + 2 * LIM_STRIDE)
        begin
          rd_hit = 1'b1;
          rd_val = 32'(s_reg.lim[c].fs);
        end
      end
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_val;
      s_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // conversion results, remote offset with saturation
    sum = {I_REMOTE_RESULT[TEMP_W-1], I_REMOTE_RESULT} + {s_reg.offset[TEMP_W-1], s_reg.offset};
    if (sum[TEMP_W] != sum[TEMP_W-1])
      rem_adj = {sum[TEMP_W], {(TEMP_W-1){!sum[TEMP_W]}}};
    else
      rem_adj = sum[TEMP_W-1:0];
    if (I_CONV_DONE)
    begin
      s_next.temp[CH_LOC] = I_LOCAL_RESULT;
      s_next.temp[CH_REM] = rem_adj;
    end
    s_next.eval = I_CONV_DONE || lim_wr;

    // sticky status, a set wins over a clear
    ev = '0;
    ev[ST_LOC_HIGH] = cmp[CH_LOC].high_exc;
    ev[ST_LOC_LOW] = cmp[CH_LOC].low_exc;
    ev[ST_REM_HIGH] = cmp[CH_REM].high_exc;
    ev[ST_REM_LOW] = cmp[CH_REM].low_exc;
    ev[ST_LOC_FS] = cmp[CH_LOC].fs_on;
    ev[ST_REM_FS] = cmp[CH_REM].fs_on;
    ev[ST_OPEN] = I_CONV_START && s_reg.sync2[PIN_OPEN];
    s_next.status = (s_reg.status & ~clr) | ev;

    // maskable alarm latch
    if (|(s_reg.status & s_reg.enable) && !s_reg.cfg[CFG_MASK_BIT])
      s_next.alarm_on = 1'b1;
    else if (I_ARA_READ && !any_high && s_next.status == '0)
      s_next.alarm_on = 1'b0;

    // pin drivers
    if (pin_sec)
      s_next.alarm_oe = cmp[CH_LOC].sec_on || cmp[CH_REM].sec_on;
    else
      s_next.alarm_oe = s_reg.alarm_on;
    s_next.fs_oe = cmp[CH_LOC].fs_on || cmp[CH_REM].fs_on;
    s_next.irq = |(s_next.status & s_next.enable);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.hyst <= HYST_RST;
      s_reg.offset <= OFFSET_RST;
      s_reg.enable <= ENABLE_RST;
      s_reg.cfg <= CFG_RST;
      for (int c = 0; c < NCH; c++)
      begin
        s_reg.lim[c].high <= HIGH_RST;
        s_reg.lim[c].low <= LOW_RST;
        s_reg.lim[c].fs <= FS_RST;
      end
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_AWREADY = aw_rdy;
  assign O_WREADY = w_rdy;
  assign O_BVALID = s_reg.bvalid;
  assign O_BRESP = s_reg.bresp;
  assign O_ARREADY = ar_rdy;
  assign O_RVALID = s_reg.rvalid;
  assign O_RDATA = s_reg.rdata;
  assign O_RRESP = s_reg.rresp;
  assign O_ARA_ANSWER = s_reg.alarm_on && !s_reg.cfg[CFG_PIN_BIT];
  assign O_ARA_ADDR = DEV_ADDR;
  assign O_LIMIT_ALARM_N = 1'b0;
  assign O_LIMIT_ALARM_OE = s_reg.alarm_oe;
  assign O_OVERTEMP_FAILSAFE_N = 1'b0;
  assign O_OVERTEMP_FAILSAFE_OE = s_reg.fs_oe;
  assign O_IRQ = s_reg.irq;

endmodule

// >>> testbench/tao_alarm_checker.sv
// assertion checker bound to the thermal alarm top module
`timescale 1ns/1ps
module tao_alarm_checker
  import tao_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
)
(
  // clock and reset
  input wire logic I_CLK, I_RST_N,
  // register bus
  input wire logic I_AWVALID, O_AWREADY, I_WVALID, O_WREADY, O_BVALID,
  input wire logic I_ARVALID, O_ARREADY, O_RVALID,
  input wire logic [31:0] O_RDATA,
  // conversion and alert response
  input wire logic I_CONV_START, I_CONV_DONE, I_ARA_READ,
  input wire logic [6:0] O_ARA_ADDR,
  // pin enables and interrupt
  input wire logic O_LIMIT_ALARM_OE, O_OVERTEMP_FAILSAFE_OE, O_IRQ
);
  // --------------------------------------------------------------
  // cycles since the last event that may move an output
  // --------------------------------------------------------------
  logic evt;
  logic [3:0] since_reg;
  assign evt = I_CONV_START || I_CONV_DONE || I_ARA_READ || (I_AWVALID && O_AWREADY)
    || (I_WVALID && O_WREADY);
  always_ff @(posedge I_CLK or negedge I_RST_N)
    if (!I_RST_N)
      since_reg <= 4'hF;
    else if (evt)
      since_reg <= 4'h0;
    else if (since_reg != 4'hF)
      since_reg <= since_reg + 4'h1;
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_wr_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_rd_taken;
    I_ARVALID && O_ARREADY;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##[1:3] O_BVALID)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_taken |=> O_RVALID)
    else $error("read answer late");
  a_rd_upper: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
    else $error("read upper bits set");
  a_bus_refuse: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while response pending");
  a_ara_addr: assert property (O_ARA_ADDR == DEV_ADDR)
    else $error("alert response address wrong");
  a_fs_cause: assert property ($changed(O_OVERTEMP_FAILSAFE_OE) |-> since_reg <= 4'h8)
    else $error("fail-safe moved without cause");
  a_alarm_cause: assert property ($changed(O_LIMIT_ALARM_OE) |-> since_reg <= 4'h8)
    else $error("alarm pin moved without cause");
  a_irq_cause: assert property ($changed(O_IRQ) |-> since_reg <= 4'h8)
    else $error("interrupt moved without cause");
endmodule
bind tao_alarm_top tao_alarm_checker #(.DEV_ADDR(DEV_ADDR)) u_tao_alarm_checker (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
  .I_CONV_START(I_CONV_START), .I_CONV_DONE(I_CONV_DONE), .I_ARA_READ(I_ARA_READ),
  .O_ARA_ADDR(O_ARA_ADDR), .O_LIMIT_ALARM_OE(O_LIMIT_ALARM_OE),
  .O_OVERTEMP_FAILSAFE_OE(O_OVERTEMP_FAILSAFE_OE), .O_IRQ(O_IRQ));

// >>> testbench/tao_smbus_host.sv
// smbus host model: line pull-ups and alert servicing
`timescale 1ns/1ps
module tao_smbus_host
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // service request and answer latency
  input wire logic i_serve,
  input wire logic [3:0] i_lat,
  // open-drain enables
  input wire logic i_alarm_oe,
  input wire logic i_fs_oe,
  // resolved lines and alert response read
  output logic o_alarm_line_n,
  output logic o_fs_line_n,
  output logic o_ara_read
);
  logic [3:0] wait_reg;
  // pull-ups: a released line reads high
  assign o_alarm_line_n = ~i_alarm_oe;
  assign o_fs_line_n = ~i_fs_oe;
  // one alert response read per request, i_lat+1 cycles after the line falls
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_reg <= 4'h0;
      o_ara_read <= 1'b0;
    end
    else
    begin
      o_ara_read <= 1'b0;
      if (!i_serve)
        wait_reg <= 4'h0;
      else if (!o_alarm_line_n && wait_reg != 4'hF)
      begin
        wait_reg <= wait_reg + 4'h1;
        o_ara_read <= (wait_reg == i_lat);
      end
    end
  end
endmodule

// >>> testbench/tao_alarm_top_tb_top.sv
// self-checking bench of the thermal alarm outputs
`timescale 1ns/1ps
module tao_alarm_top_tb_top
  import tao_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
  logic b_rdy = 1'b0, r_rdy = 1'b0, start = 1'b0, done = 1'b0, open = 1'b0;
  logic serve = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00, loc = 8'h00, rem = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic [3:0] strb = 4'hF, lat = 4'h0;
  logic awr, wrr, bv, arr, rv, ara, ans, a_oe, f_oe, a_n, f_n, irq, a_lo, f_lo;
  logic [1:0] br, rr;
  logic [31:0] rd_d;
  logic [6:0] ara_addr;
  int err_total = 0;
  int checked = 0;
  always #20 clk = ~clk;
  tao_alarm_top u_tao_alarm_top (
    .I_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(aw_v), .O_AWREADY(awr), .I_AWADDR(aw_a),
    .I_WVALID(w_v), .O_WREADY(wrr), .I_WDATA(w_d), .I_WSTRB(strb), .O_BVALID(bv),
    .I_BREADY(b_rdy), .O_BRESP(br), .I_ARVALID(ar_v), .O_ARREADY(arr), .I_ARADDR(ar_a),
    .O_RVALID(rv), .I_RREADY(r_rdy), .O_RDATA(rd_d), .O_RRESP(rr), .I_CONV_START(start),
    .I_CONV_DONE(done), .I_LOCAL_RESULT(loc), .I_REMOTE_RESULT(rem), .I_DIODE_OPEN(open),
    .I_ARA_READ(ara), .O_ARA_ANSWER(ans), .O_ARA_ADDR(ara_addr), .I_LIMIT_ALARM_N(a_n),
    .O_LIMIT_ALARM_N(a_lo), .O_LIMIT_ALARM_OE(a_oe), .I_OVERTEMP_FAILSAFE_N(f_n),
    .O_OVERTEMP_FAILSAFE_N(f_lo), .O_OVERTEMP_FAILSAFE_OE(f_oe), .O_IRQ(irq));
  tao_smbus_host u_tao_smbus_host (.i_clk(clk), .i_rst_n(rst_n), .i_serve(serve),
    .i_lat(lat), .i_alarm_oe(a_oe), .i_fs_oe(f_oe), .o_alarm_line_n(a_n),
    .o_fs_line_n(f_n), .o_ara_read(ara));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang;
    chk(32'h0, 32'h1);
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    aw_a <= a;
    w_d <= d;
    strb <= s;
    b_rdy <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (awr) aw_v <= 1'b0;
      if (wrr) w_v <= 1'b0;
      if (bv) break;
    end
    if (n == 40) hang();
    chk(32'(br), 32'(er));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    ar_v <= 1'b1;
    ar_a <= a;
    r_rdy <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (arr) ar_v <= 1'b0;
      if (rv) break;
    end
    if (n == 40) hang();
    chk(32'(rr), 32'(er));
    if (er == RESP_OKAY) chk(rd_d, e);
  endtask
  task automatic conv(input logic [7:0] l, input logic [7:0] r);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    done <= 1'b1;
    loc <= l;
    rem <= r;
    @(posedge clk);
    done <= 1'b0;
    // store, compare, status, latch and pin stages settle within six edges
    repeat (6) @(posedge clk);
  endtask
  task automatic svc(input logic [3:0] l);
    int n;
    lat <= l;
    serve <= 1'b1;
    for (n = 0; n < 24 && !ara; n++) @(posedge clk);
    if (n == 24) hang();
    serve <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic pins(input logic [1:0] e);
    chk(32'({a_n, f_n, a_lo, f_lo}), 32'({e, 2'b00}));
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs;
    rchk(OFF_HYST, 32'(HYST_RST), RESP_OKAY);
    rchk(OFF_LIM_BASE, 32'(HIGH_RST), RESP_OKAY);
    wr(OFF_HYST, 32'h4, 4'h0, RESP_OKAY);
    rchk(OFF_HYST, 32'(HYST_RST), RESP_OKAY);
    wr(8'h3C, 32'h0, 4'hF, RESP_SLVERR);
    rchk(8'h3C, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_alarm;
    conv(8'h56, 8'h00);
    pins(2'b01);
    chk(32'({irq, ans}), 32'h3);
    chk(32'(ara_addr), 32'(DEV_ADDR_DEF));
    wr(OFF_CLEAR, 32'h7F, 4'hF, RESP_OKAY);
    svc(4'h0);
    pins(2'b01);
    conv(8'h55, 8'h00);
    wr(OFF_CLEAR, 32'h7F, 4'hF, RESP_OKAY);
    svc(4'h5);
    pins(2'b11);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_fs;
    // fail-safe limits stay at their defaults, above the high limits
    wr(OFF_CONFIG, 32'h1, 4'hF, RESP_OKAY);
    conv(8'h5B, 8'h00);
    pins(2'b10);
    conv(8'h51, 8'h00);
    pins(2'b10);
    conv(8'h50, 8'h00);
    pins(2'b11);
    wr(OFF_HYST, 32'h3, 4'hF, RESP_OKAY);
    conv(8'h00, 8'h5B);
    pins(2'b10);
    conv(8'h00, 8'h58);
    pins(2'b10);
    conv(8'h00, 8'h57);
    pins(2'b11);
  endtask
  task automatic t_sec;
    wr(OFF_CONFIG, 32'h3, 4'hF, RESP_OKAY);
    conv(8'h56, 8'h00);
    pins(2'b01);
    conv(8'h53, 8'h00);
    pins(2'b01);
    conv(8'h52, 8'h00);
    pins(2'b11);
  endtask
  task automatic t_diode;
    wr(OFF_CONFIG, 32'h0, 4'hF, RESP_OKAY);
    wr(OFF_CLEAR, 32'h7F, 4'hF, RESP_OKAY);
    svc(4'h1);
    pins(2'b11);
    open <= 1'b1;
    repeat (3) @(posedge clk);
    conv(8'h00, 8'h00);
    rchk(OFF_STATUS, 32'h4, RESP_OKAY);
    pins(2'b01);
    rchk(OFF_PINS, 32'h3, RESP_OKAY);
    wr(OFF_ENABLE, 32'h0, 4'hF, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(OFF_ENABLE, 32'(ENABLE_RST), 4'hF, RESP_OKAY);
    open <= 1'b0;
    repeat (3) @(posedge clk);
    conv(8'h00, 8'h00);
    wr(OFF_CLEAR, 32'h7F, 4'hF, RESP_OKAY);
    svc(4'h0);
    pins(2'b11);
    wr(OFF_OFFSET, 32'h5, 4'hF, RESP_OKAY);
    conv(8'h00, 8'h10);
    rchk(OFF_REM_TEMP, 32'h15, RESP_OKAY);
    wr(OFF_LIM_BASE + CH_STRIDE + LIM_STRIDE, 32'h15, 4'hF, RESP_OKAY);
    repeat (4) @(posedge clk);
    pins(2'b01);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_alarm();
    t_fs();
    t_sec();
    t_diode();
    results();
  end
endmodule
